//--- core/rcs_sequencer.sv
// command launch, busy and status sequencing for the striped array
module rcs_sequencer (
    input wire logic CLK,
    input wire logic RESET,
    // host side
    input wire logic CMD_WRITE_STB,
    input wire logic [2:0] COMMAND_WORD,
    input wire logic [rcs_pkg::ADDR_W-1:0] START_ADDRESS_WORDS,
    input wire logic [rcs_pkg::ADDR_W-1:0] LENGTH_WORDS,
    input wire logic [2:0] PATTERN_SELECT,
    output logic [2:0] USER_STATUS_WORD,
    output logic [rcs_pkg::NCH*32-1:0] LINK_STATUS_WORD,
    output logic [rcs_pkg::NCH*32-1:0] CHANNEL_ERROR_TYPE,
    output logic [rcs_pkg::BYTE_W-1:0] PROGRESS_BYTE_COUNT,
    output logic [rcs_pkg::BYTE_W-1:0] FAIL_BYTE_ADDRESS,
    output logic [rcs_pkg::PAT_W-1:0] EXPECTED_PATTERN_WORDS,
    output logic [rcs_pkg::PAT_W-1:0] READ_PATTERN_WORDS,
    output logic SHUTDOWN_DONE,
    // core side
    output logic CORE_REQ,
    output logic [2:0] CORE_CMD,
    output logic [rcs_pkg::ADDR_W-1:0] CORE_ADDR,
    output logic [rcs_pkg::ADDR_W-1:0] CORE_LEN,
    output logic [2:0] CORE_PATTERN,
    output logic CORE_ACTIVE,
    input wire logic CORE_BUSY,
    input wire logic CORE_ERROR,
    input wire logic [rcs_pkg::NCH*32-1:0] CORE_ERROR_TYPE,
    input wire logic [rcs_pkg::NCH-1:0] CORE_LINK_UP,
    input wire logic [rcs_pkg::NCH*3-1:0] CORE_LINK_SPEED,
    input wire logic [rcs_pkg::NCH*3-1:0] CORE_LINK_WIDTH,
    input wire logic [rcs_pkg::NCH*6-1:0] CORE_LINK_LTSSM,
    input wire logic BEAT_VALID,
    input wire logic [rcs_pkg::PAT_W-1:0] BEAT_EXPECTED,
    input wire logic [rcs_pkg::PAT_W-1:0] BEAT_READ
);
    typedef enum logic [1:0] {ST_IDLE, ST_LAUNCH, ST_RUN, ST_DEAD} rcs_state_t;

    rcs_state_t state_reg, state_next;
    logic busy_reg;
    logic error_reg;
    logic req_reg;
    logic [2:0] cmd_reg;
    logic [rcs_pkg::ADDR_W-1:0] addr_reg;
    logic [rcs_pkg::ADDR_W-1:0] len_reg;
    logic [2:0] pat_reg;
    logic shut_reg;
    logic active_reg;
    logic [rcs_pkg::NCH*32-1:0] link_reg;
    logic [rcs_pkg::NCH*32-1:0] errtype_reg;
    logic [rcs_pkg::BYTE_W-1:0] count_reg;
    logic [rcs_pkg::BYTE_W-1:0] faddr_reg;
    logic [rcs_pkg::PAT_W-1:0] fexp_reg;
    logic [rcs_pkg::PAT_W-1:0] frd_reg;
    logic vfail_reg;

    rcs_core_if core_bus ();

    // =====================================================
    // command decode
    wire logic code_legal = (COMMAND_WORD != rcs_pkg::CMD_RSVD5)
        && (COMMAND_WORD != rcs_pkg::CMD_RSVD7);
    // a busy core or a dead array makes the write a no-op
    wire logic accept = CMD_WRITE_STB && code_legal && !busy_reg && !CORE_BUSY
        && (state_reg == ST_IDLE);
    wire logic is_read = (cmd_reg == rcs_pkg::CMD_READ);
    wire logic is_shut = (cmd_reg == rcs_pkg::CMD_SHUTDOWN);
    wire logic op_start = (state_reg == ST_LAUNCH);
    wire logic op_done = (state_reg == ST_RUN) && !core_bus.busy;
    wire logic [rcs_pkg::BYTE_W-1:0] v_count;
    wire logic v_fail;
    wire logic [rcs_pkg::BYTE_W-1:0] v_addr;
    wire logic [rcs_pkg::PAT_W-1:0] v_exp;
    wire logic [rcs_pkg::PAT_W-1:0] v_rd;
    wire logic [rcs_pkg::NCH*32-1:0] link_next;

    assign core_bus.req = req_reg;
    assign core_bus.cmd = cmd_reg;
    assign core_bus.busy = CORE_BUSY;
    assign core_bus.error = CORE_ERROR;
    assign core_bus.active = active_reg;

    // =====================================================
    // link status packing per channel
    genvar ch;
    generate
        for (ch = 0; ch < rcs_pkg::NCH; ch++)
        begin : g_link
            assign link_next[ch*32 +: 32] = {15'h0,
                CORE_LINK_SPEED[ch*3+2], 1'b0, 1'b0,
                CORE_LINK_LTSSM[ch*6 +: 6], 1'b0,
                CORE_LINK_WIDTH[ch*3 +: 3],
                CORE_LINK_SPEED[ch*3 +: 2], 1'b0,
                CORE_LINK_UP[ch]};
        end
    endgenerate

    // =====================================================
    // state machine
    always_comb
    begin
        state_next = state_reg;
        unique case (state_reg)
            ST_IDLE:
                if (accept)
                    state_next = ST_LAUNCH;
            // one cycle of request before the core's busy can be trusted
            ST_LAUNCH:
                state_next = ST_RUN;
            ST_RUN:
                if (op_done)
                    state_next = is_shut ? ST_DEAD : ST_IDLE;
            ST_DEAD:
                state_next = ST_DEAD;
        endcase
    end

    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            state_reg <= ST_IDLE;
            busy_reg <= 1'b1;
            error_reg <= 1'b0;
            req_reg <= 1'b0;
            cmd_reg <= rcs_pkg::CMD_IDENTIFY;
            addr_reg <= '0;
            len_reg <= '0;
            pat_reg <= 3'h0;
            shut_reg <= 1'b0;
            active_reg <= 1'b1;
            link_reg <= '0;
            errtype_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            link_reg <= link_next;
            errtype_reg <= CORE_ERROR_TYPE;
            req_reg <= accept;
            if (accept)
            begin
                cmd_reg <= COMMAND_WORD;
                addr_reg <= START_ADDRESS_WORDS;
                len_reg <= LENGTH_WORDS;
                pat_reg <= PATTERN_SELECT;
            end
            // busy follows the core at idle, covering its start-up phase
            if (state_reg == ST_IDLE)
                busy_reg <= CORE_BUSY || accept;
            else if (op_done)
                busy_reg <= 1'b0;
            else if (state_reg != ST_DEAD)
                busy_reg <= 1'b1;
            // error is sticky until reset; the host stops on it
            if (core_bus.error)
                error_reg <= 1'b1;
            // active kept as its own flop so the pin is glitch free
            if (op_done && is_shut)
            begin
                shut_reg <= 1'b1;
                active_reg <= 1'b0;
            end
        end
    end

    // =====================================================
    // verification and progress
    rcs_verify u_verify (
        .clk(CLK),
        .rst(RESET),
        .start(op_start),
        .is_read(is_read),
        .beat_valid(BEAT_VALID),
        .beat_expected(BEAT_EXPECTED),
        .beat_read(BEAT_READ),
        .byte_count(v_count),
        .fail(v_fail),
        .fail_addr(v_addr),
        .fail_expected(v_exp),
        .fail_read(v_rd)
    );

    // registered copies keep every top output straight off a flop
    always_ff @(posedge CLK)
    begin
        if (RESET)
        begin
            count_reg <= rcs_pkg::BYTE_RESET;
            faddr_reg <= rcs_pkg::BYTE_RESET;
            fexp_reg <= rcs_pkg::PAT_RESET;
            frd_reg <= rcs_pkg::PAT_RESET;
            vfail_reg <= 1'b0;
        end
        else
        begin
            count_reg <= v_count;
            faddr_reg <= v_addr;
            fexp_reg <= v_exp;
            frd_reg <= v_rd;
            vfail_reg <= v_fail;
        end
    end

    assign USER_STATUS_WORD = {vfail_reg, error_reg, busy_reg};
    assign LINK_STATUS_WORD = link_reg;
    assign CHANNEL_ERROR_TYPE = errtype_reg;
    assign PROGRESS_BYTE_COUNT = count_reg;
    assign FAIL_BYTE_ADDRESS = faddr_reg;
    assign EXPECTED_PATTERN_WORDS = fexp_reg;
    assign READ_PATTERN_WORDS = frd_reg;
    assign SHUTDOWN_DONE = shut_reg;
    assign CORE_REQ = core_bus.req;
    assign CORE_CMD = core_bus.cmd;
    assign CORE_ADDR = addr_reg;
    assign CORE_LEN = len_reg;
    assign CORE_PATTERN = pat_reg;
    assign CORE_ACTIVE = core_bus.active;
endmodule

//--- core/rcs_pkg.sv
// shared constants for the striped-array command sequencer
package rcs_pkg;
    // =====================================================
    // command codes
    localparam logic [2:0] CMD_IDENTIFY = 3'h0;
    localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
    localparam logic [2:0] CMD_WRITE = 3'h2;
    localparam logic [2:0] CMD_READ = 3'h3;
    localparam logic [2:0] CMD_HEALTH = 3'h4;
    localparam logic [2:0] CMD_RSVD5 = 3'h5;
    localparam logic [2:0] CMD_FLUSH = 3'h6;
    localparam logic [2:0] CMD_RSVD7 = 3'h7;
    // =====================================================
    // status word field positions
    localparam int STS_BUSY = 0;
    localparam int STS_ERROR = 1;
    localparam int STS_VERIFY = 2;
    localparam logic [2:0] STS_RESET = 3'h0;
    // =====================================================
    // link status word layout
    localparam int LINK_UP_BIT = 0;
    localparam int LINK_SPEED_LO = 2;
    localparam int LINK_WIDTH_LO = 4;
    localparam int LINK_LTSSM_LO = 8;
    localparam int LINK_SPEED_HI = 16;
    localparam logic [31:0] LINK_RESET = 32'h0;
    // =====================================================
    // widths and sizes
    localparam int NCH = 4;
    localparam int ADDR_W = 48;
    localparam int BYTE_W = 57;
    localparam int PAT_W = 1024;
    localparam logic [56:0] BYTE_RESET = 57'h0;
    localparam logic [PAT_W-1:0] PAT_RESET = '0;
    // bytes moved per data beat of the core interface
    localparam logic [56:0] BEAT_BYTES = 57'h80;
endpackage

//--- core/rcs_core_if.sv
// request and completion signals toward the striped array core
interface rcs_core_if;
    logic req;
    logic [2:0] cmd;
    logic busy;
    logic error;
    logic active;
    modport seq (output req, output cmd, input busy, input error, output active);
    modport core (input req, input cmd, output busy, output error, input active);
endinterface

//--- core/rcs_verify.sv
// data beat checker: byte progress count over every beat and first read mismatch capture
module rcs_verify (
    input wire logic clk,
    input wire logic rst,
    input wire logic start,
    input wire logic is_read,
    input wire logic beat_valid,
    input wire logic [rcs_pkg::PAT_W-1:0] beat_expected,
    input wire logic [rcs_pkg::PAT_W-1:0] beat_read,
    output logic [rcs_pkg::BYTE_W-1:0] byte_count,
    output logic fail,
    output logic [rcs_pkg::BYTE_W-1:0] fail_addr,
    output logic [rcs_pkg::PAT_W-1:0] fail_expected,
    output logic [rcs_pkg::PAT_W-1:0] fail_read
);
    logic [rcs_pkg::BYTE_W-1:0] count_reg;
    logic fail_reg;
    logic [rcs_pkg::BYTE_W-1:0] addr_reg;
    logic [rcs_pkg::PAT_W-1:0] exp_reg;
    logic [rcs_pkg::PAT_W-1:0] rd_reg;
    wire logic mismatch = beat_valid && is_read && (beat_expected != beat_read);
    // only the first mismatch is kept; later ones would hide the root cause
    wire logic capture = mismatch && !fail_reg;

    // =====================================================
    // progress and capture
    always_ff @(posedge clk)
    begin
        if (rst || start)
        begin
            count_reg <= rcs_pkg::BYTE_RESET;
            fail_reg <= 1'b0;
            addr_reg <= rcs_pkg::BYTE_RESET;
            exp_reg <= rcs_pkg::PAT_RESET;
            rd_reg <= rcs_pkg::PAT_RESET;
        end
        else
        begin
            if (beat_valid)
            begin
                count_reg <= count_reg + rcs_pkg::BEAT_BYTES;
            end
            if (capture)
            begin
                fail_reg <= 1'b1;
                addr_reg <= count_reg;
                exp_reg <= beat_expected;
                rd_reg <= beat_read;
            end
        end
    end

    assign byte_count = count_reg;
    assign fail = fail_reg;
    assign fail_addr = addr_reg;
    assign fail_expected = exp_reg;
    assign fail_read = rd_reg;
endmodule

//--- dv/rcs_seq_props.sv
// concurrent checks on the command sequencer ports
module rcs_seq_props (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CMD_WRITE_STB,
    input wire logic [2:0] COMMAND_WORD,
    input wire logic [2:0] USER_STATUS_WORD,
    input wire logic [rcs_pkg::NCH*32-1:0] LINK_STATUS_WORD,
    input wire logic SHUTDOWN_DONE,
    input wire logic CORE_REQ,
    input wire logic [2:0] CORE_CMD,
    input wire logic CORE_ACTIVE,
    input wire logic CORE_BUSY,
    input wire logic CORE_ERROR,
    input wire logic [rcs_pkg::NCH*3-1:0] CORE_LINK_SPEED,
    input wire logic [rcs_pkg::NCH*3-1:0] CORE_LINK_WIDTH
);
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================================
    // helpers
    // reserved codes are the only ones with both outer bits set
    wire take = CMD_WRITE_STB && !(COMMAND_WORD[2] && COMMAND_WORD[0]) && !USER_STATUS_WORD[0]
        && !CORE_BUSY && !SHUTDOWN_DONE;
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    // =====================================================
    // assertions
    a_take_launch: assert property (take |=> CORE_REQ && USER_STATUS_WORD[0]
        && CORE_CMD == $past(COMMAND_WORD)) else $error("accepted command not launched");
    a_req_cause: assert property (CORE_REQ |-> $past(take))
        else $error("request without accepted write");
    a_busy_refuse: assert property (CMD_WRITE_STB && USER_STATUS_WORD[0] |=> !CORE_REQ)
        else $error("write taken while busy");
    a_req_pulse: assert property (CORE_REQ |=> !CORE_REQ && USER_STATUS_WORD[0])
        else $error("request not a single pulse");
    a_busy_follow: assert property (CORE_BUSY |=> USER_STATUS_WORD[0])
        else $error("busy low while core busy");
    a_busy_clear: assert property ($fell(CORE_BUSY) |-> ##[1:3] !USER_STATUS_WORD[0])
        else $error("busy did not clear");
    a_error_flag: assert property (CORE_ERROR |-> ##[1:3] USER_STATUS_WORD[1])
        else $error("error bit not set");
    a_shut_final: assert property (SHUTDOWN_DONE |=> SHUTDOWN_DONE && !CORE_REQ
        && !CORE_ACTIVE) else $error("activity after shutdown");
    a_link_copy: assert property (!$past(RESET) |-> LINK_STATUS_WORD[6:2]
        == {$past(CORE_LINK_WIDTH[2:0]), $past(CORE_LINK_SPEED[1:0])}
        && LINK_STATUS_WORD[16] == $past(CORE_LINK_SPEED[2])) else $error("link word wrong");
    c_read: cover property (CORE_REQ && CORE_CMD == rcs_pkg::CMD_READ);
    c_verify: cover property (USER_STATUS_WORD[2]);
    c_shut: cover property (SHUTDOWN_DONE);
endmodule
bind rcs_sequencer rcs_seq_props i_rcs_seq_props (.CLK, .RESET, .CMD_WRITE_STB, .COMMAND_WORD,
    .USER_STATUS_WORD, .LINK_STATUS_WORD, .SHUTDOWN_DONE, .CORE_REQ, .CORE_CMD, .CORE_ACTIVE,
    .CORE_BUSY, .CORE_ERROR, .CORE_LINK_SPEED, .CORE_LINK_WIDTH);

//--- dv/rcs_core_model.sv
// behavioural striped array core: init wait, busy, data beats, faults
module rcs_core_model (
    input wire logic clk,
    input wire logic rst,
    input wire logic req,
    input wire logic [2:0] cmd,
    input wire logic [7:0] dly,
    input wire logic err_en,
    input wire logic [7:0] bad_beat,
    output logic busy,
    output logic error,
    output logic beat_valid,
    output logic [rcs_pkg::PAT_W-1:0] beat_exp,
    output logic [rcs_pkg::PAT_W-1:0] beat_rd
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] cnt_reg;
    logic xfer_reg;
    assign beat_valid = xfer_reg && busy && cnt_reg != 8'h00;
    assign beat_exp = {32{24'ha5a500, cnt_reg}};
    // idle data lines show the inverse so stale values never match
    assign beat_rd = !beat_valid ? ~beat_exp : cnt_reg == bad_beat ?
        {beat_exp[1023:1], ~beat_exp[0]} : beat_exp;
    always @(posedge clk)
    begin
        error <= 1'b0;
        if (rst)
        begin
            busy <= 1'b1;
            cnt_reg <= 8'h06;
            xfer_reg <= 1'b0;
        end
        else if (req)
        begin
            busy <= 1'b1;
            cnt_reg <= dly;
            xfer_reg <= cmd[2:1] == 2'b01;
        end
        else if (cnt_reg != 8'h00)
            cnt_reg <= cnt_reg - 8'h01;
        else
        begin
            busy <= 1'b0;
            error <= busy & err_en;
        end
    end
endmodule

//--- dv/rcs_sequencer_bench.sv
// self-checking bench for the striped-array command sequencer
module rcs_sequencer_bench;
    timeunit 1ns;
    timeprecision 1ns;
    // =====================================================
    // stimulus and wiring
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic stb = 1'b0;
    logic [2:0] code = 3'h0;
    logic [7:0] dly = 8'h04;
    logic err_en = 1'b0;
    logic [7:0] bad = 8'h00;
    logic [47:0] adr = 48'h0123456789ab;
    logic [47:0] len = 48'h000000000010;
    logic [2:0] pat = 3'h4;
    logic [3:0] lup = 4'h0;
    logic [127:0] lnk;
    logic req, cbusy, cerr, bv, act, shut;
    logic [2:0] sts, ccmd, cpat;
    logic [127:0] link, etype;
    logic [56:0] prog, faddr;
    logic [47:0] caddr, clen;
    logic [1023:0] pexp, prd, bexp, brd;
    logic [2:0] ops [5] = '{3'h0, 3'h2, 3'h3, 3'h4, 3'h6};
    int compares = 0;
    int n_fail = 0;
    rcs_sequencer i_rcs_sequencer (
        .CLK(clk), .RESET(rst), .CMD_WRITE_STB(stb), .COMMAND_WORD(code),
        .START_ADDRESS_WORDS(adr), .LENGTH_WORDS(len), .PATTERN_SELECT(pat),
        .USER_STATUS_WORD(sts), .LINK_STATUS_WORD(link), .CHANNEL_ERROR_TYPE(etype),
        .PROGRESS_BYTE_COUNT(prog), .FAIL_BYTE_ADDRESS(faddr), .EXPECTED_PATTERN_WORDS(pexp),
        .READ_PATTERN_WORDS(prd), .SHUTDOWN_DONE(shut), .CORE_REQ(req), .CORE_CMD(ccmd),
        .CORE_ADDR(caddr), .CORE_LEN(clen), .CORE_PATTERN(cpat), .CORE_ACTIVE(act),
        .CORE_BUSY(cbusy), .CORE_ERROR(cerr), .CORE_ERROR_TYPE({4{32'h00000010}}),
        .CORE_LINK_UP(lup), .CORE_LINK_SPEED({4{3'h7}}), .CORE_LINK_WIDTH({4{3'h4}}),
        .CORE_LINK_LTSSM({4{6'h11}}), .BEAT_VALID(bv), .BEAT_EXPECTED(bexp), .BEAT_READ(brd)
    );
    rcs_core_model i_rcs_core_model (
        .clk(clk), .rst(rst), .req(req), .cmd(ccmd), .dly(dly), .err_en(err_en),
        .bad_beat(bad), .busy(cbusy), .error(cerr), .beat_valid(bv), .beat_exp(bexp),
        .beat_rd(brd)
    );
    // =====================================================
    // tasks
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic issue(input logic [2:0] c, input logic acc);
        @(negedge clk);
        stb = 1'b1;
        code = c;
        @(negedge clk);
        stb = 1'b0;
        chk(64'({req, sts[0] & acc}), 64'({acc, acc}));
        if (acc)
            chk(64'(ccmd), 64'(c));
    endtask
    // host rereads link words until two reads agree and link-up is set
    task automatic poll_link(output logic [127:0] val);
        logic [127:0] prev;
        int n;
        prev = link;
        n = 0;
        @(negedge clk);
        while ((link !== prev || link[0] !== 1'b1) && n < 50)
        begin
            prev = link;
            @(negedge clk);
            n++;
        end
        val = link;
        chk(64'(n < 50), 64'h1);
    endtask
    // bounded so a stuck busy ends as a mismatch, not a hang
    task automatic wait_idle();
        int n;
        n = 0;
        while (sts[0] !== 1'b0 && n < 500)
        begin
            @(negedge clk);
            n++;
        end
        chk(64'(n < 500), 64'h1);
    endtask
    task automatic print_verdict();
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // =====================================================
    // clock, watchdog, tests
    initial
    begin
        forever #25 clk = ~clk;
    end
    initial
    begin
        repeat (4000) @(posedge clk);
        n_fail++;
        print_verdict();
    end
    initial
    begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        @(negedge clk);
        chk(64'(sts), 64'h1);
        chk(64'(link[0]), 64'h0);
        lup = 4'hf;
        poll_link(lnk);
        wait_idle();
        chk(lnk[63:0], {2{32'h0001114d}});
        chk(link[127:64], {2{32'h0001114d}});
        for (int i = 0; i < 5; i++)
        begin
            dly = 8'(1 + i * 7);
            issue(ops[i], 1'b1);
            wait_idle();
            chk(64'(sts), 64'h0);
            chk(64'(prog), ops[i][2:1] == 2'b01 ? 64'(dly) * 64'h80 : 64'h0);
        end
        chk({caddr[31:0], clen[31:0]}, {adr[31:0], len[31:0]});
        issue(3'h5, 1'b0);
        issue(3'h7, 1'b0);
        dly = 8'h14;
        issue(3'h0, 1'b1);
        issue(3'h2, 1'b0);
        chk(64'(ccmd), 64'h0);
        wait_idle();
        dly = 8'h08;
        bad = 8'h03;
        adr = 48'hfedc00001234;
        len = 48'h00aa00000008;
        pat = 3'h2;
        issue(3'h3, 1'b1);
        chk(64'(caddr), 64'(adr));
        chk(64'(clen), 64'(len));
        chk(64'(cpat), 64'(pat));
        wait_idle();
        chk(64'(sts), 64'h4);
        chk(64'(prog), 64'h400);
        chk(64'(faddr), 64'h280);
        chk(pexp[63:0], {2{32'ha5a50003}});
        chk(prd[63:0], {2{32'ha5a50003}} ^ 64'h1);
        err_en = 1'b1;
        issue(3'h6, 1'b1);
        wait_idle();
        chk(64'(sts), 64'h2);
        chk(etype[63:0], {2{32'h00000010}});
        err_en = 1'b0;
        issue(3'h1, 1'b1);
        wait_idle();
        chk(64'({shut, act}), 64'h2);
        issue(3'h0, 1'b0);
        print_verdict();
    end
endmodule
